// ### core/program_sequencer.sv
// Program counter, return stack, table read path and ALU step of the 8-bit core
//
// Contract
// RULE_01 - PC steps by one after each instruction unless control transfers elsewhere.
// RULE_02 - Software sees only the PC low byte; upper bits are hidden.
// RULE_03 - Jump, call, interrupt entry and reset load the target into the PC.
// RULE_04 - A taken skip turns the prefetched instruction into a dummy cycle.
// RULE_05 - Program memory is 2048 words of 16 bits addressed by the PC.
// RULE_06 - PC low byte is read/write; a write jumps within the current page.
// RULE_07 - Every PC low byte write inserts one dummy cycle.
// RULE_08 - Return stack holds PC values only; no software access to it or its level.
// RULE_09 - Call and interrupt acknowledge push the current PC.
// RULE_10 - Return and interrupt return pop the stack into the PC.
// RULE_11 - Reset empties the stack.
// RULE_12 - Interrupt with full stack stays flagged; acknowledged once a return frees a level.
// RULE_13 - A call with full stack still executes.
// RULE_14 - Overflow drops the oldest saved PC and keeps the newest.
// RULE_15 - ALU writes its result and updates carry, borrow and other flags.
// RULE_16 - ALU covers add, carry, decimal adjust, logic, rotates, inc, dec.
// RULE_17 - Reset loads the PC with address zero.
// RULE_18 - Table pointer low and high registers form the table word address.
// RULE_19 - Table read writes low byte to data memory, high byte to table high byte.
// RULE_20 - Instruction cycle has four phases; fetch starts in the first.
// RULE_21 - Jumps and calls take two instruction cycles.
// RULE_22 - Table reads take two instruction cycles.
// RULE_23 - Table high byte is read-only; only table reads update it.
// RULE_24 - Stack depth is a parameter; full and overflow derive from it.
`timescale 1ns/100ps
`default_nettype none

module program_sequencer #(
	parameter int STACK_DEPTH = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output var  logic [31:0]      prdata,
	output var  logic             pready,
	output var  logic             pslverr,
	input  wire seq_pkg::seq_cmd_t cmd,
	input  wire logic             int_req,
	input  wire logic [15:0]      pmem_rdata,
	output var  logic [10:0]      pmem_addr,
	output var  logic [15:0]      instr,
	output var  logic             instr_valid,
	output var  seq_pkg::phase_t  cycle_phases,
	output var  seq_pkg::data_wr_t data_wr,
	output var  logic [3:0]       status_flags,
	output var  logic             int_ack,
	output var  logic             stack_overflow
);
	// ==========================================================
	// Declarations
	localparam int LVL_W = $clog2(STACK_DEPTH + 1);
	localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(STACK_DEPTH);
	localparam logic [LVL_W-1:0] LVL_ONE  = LVL_W'(1);

	logic [10:0]      pc_reg;
	logic [10:0]      pc_next;
	logic [10:0]      stack_reg [STACK_DEPTH];
	logic [LVL_W-1:0] level_reg;
	logic             pcl_pend_reg;
	logic [7:0]       pcl_data_reg;
	logic [7:0]       tblp_reg;
	logic [2:0]       tbhp_reg;
	logic [7:0]       table_high_byte_reg;
	logic [7:0]       tbl_dest_reg;
	logic             table_cycle_reg;
	logic             int_flag_reg;
	logic [10:0]      tbl_addr;
	logic             t4;
	logic             full;
	logic             push;
	logic             pop;
	logic             discard;
	logic             tbl_start;
	logic             int_take;
	logic             apb_done;
	seq_pkg::seq_op_t op_eff;
	logic [11:0]      alu_out;

	// Register decode, used only for the error answer; read data decodes the address on its own
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == seq_pkg::OFS_PC_LOW) || (a == seq_pkg::OFS_TBL_PTR_L) ||
			(a == seq_pkg::OFS_TBL_PTR_H) || (a == seq_pkg::OFS_TBL_HIGH) ||
			(a == seq_pkg::OFS_STATUS);
	endfunction : addr_ok

	// ALU: returns {ov, z, ac, c, result}; flags an op does not touch pass through
	function automatic logic [11:0] alu_f(input seq_pkg::alu_op_t op, input logic [7:0] a,
		input logic [7:0] m, input logic [3:0] fl);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		logic       c;
		logic       ac;
		logic       ov;
		logic       z;
		logic       ci;
		s  = 9'h000;
		h  = 5'h00;
		c  = fl[seq_pkg::FLAG_C];
		ac = fl[seq_pkg::FLAG_AC];
		ov = fl[seq_pkg::FLAG_OV];
		ci = c;
		r  = 8'h00;
		case (op)
			seq_pkg::ALU_ADD, seq_pkg::ALU_ADC: begin
				s  = {1'b0, a} + {1'b0, m} + {8'h00, (op == seq_pkg::ALU_ADC) & ci};
				h  = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, (op == seq_pkg::ALU_ADC) & ci};
				r  = s[7:0];
				c  = s[8];
				ac = h[4];
				ov = (a[7] == m[7]) && (r[7] != a[7]);
			end
			seq_pkg::ALU_SUB, seq_pkg::ALU_SBC: begin
				// Carry set means no borrow
				s  = {1'b0, a} + {1'b0, ~m} + {8'h00, (op == seq_pkg::ALU_SUB) | ci};
				h  = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, (op == seq_pkg::ALU_SUB) | ci};
				r  = s[7:0];
				c  = s[8];
				ac = h[4];
				ov = (a[7] != m[7]) && (r[7] != a[7]);
			end
			seq_pkg::ALU_DAA: begin
				s = {1'b0, a};
				if ((a[3:0] > 4'h9) || ac) begin
					s = s + 9'h006;
				end
				if ((s[7:4] > 4'h9) || c || s[8]) begin
					s = s + 9'h060;
					c = 1'b1;
				end
				r = s[7:0];
			end
			seq_pkg::ALU_AND: r = a & m;
			seq_pkg::ALU_OR:  r = a | m;
			seq_pkg::ALU_XOR: r = a ^ m;
			seq_pkg::ALU_CPL: r = ~m;
			seq_pkg::ALU_RR:  r = {m[0], m[7:1]};
			seq_pkg::ALU_RRC: begin
				r = {ci, m[7:1]};
				c = m[0];
			end
			seq_pkg::ALU_RL:  r = {m[6:0], m[7]};
			seq_pkg::ALU_RLC: begin
				r = {m[6:0], ci};
				c = m[7];
			end
			seq_pkg::ALU_INC: r = m + 8'h01;
			seq_pkg::ALU_DEC: r = m - 8'h01;
			default:          r = a;
		endcase
		z = (r == 8'h00);
		alu_f = {ov, z, ac, c, r};
	endfunction : alu_f

	// ==========================================================
	// Control decisions, all taken at the close of the fourth phase
	assign t4       = (cycle_phases == seq_pkg::PH_T4);
	assign full     = (level_reg == LVL_FULL); // RULE_24
	assign op_eff   = instr_valid ? cmd.op : seq_pkg::OP_NEXT;
	assign apb_done = psel && penable && pready;
	assign alu_out  = alu_f(cmd.alu, cmd.opa, cmd.opm, status_flags);

	// Table word address from both pointer registers or the last page
	assign tbl_addr = (op_eff == seq_pkg::OP_TABLE_READ_LAST_PAGE_OP) ? {seq_pkg::LAST_PAGE, tblp_reg} // RULE_18
		: {tbhp_reg, tblp_reg};

	// Next PC; a pending low byte write outranks the decoder's control request
	always_comb begin
		pc_next   = pc_reg + seq_pkg::PC_STEP; // RULE_01
		push      = 1'b0;
		pop       = 1'b0;
		discard   = 1'b0;
		tbl_start = 1'b0;
		int_take  = 1'b0;
		if (table_cycle_reg) begin
			pc_next = pc_reg + seq_pkg::PC_STEP;
		end else if (pcl_pend_reg) begin
			pc_next = {pc_reg[10:8], pcl_data_reg}; // RULE_06
			discard = 1'b1; // RULE_07
		end else begin
			case (op_eff)
				seq_pkg::OP_JUMP: begin
					pc_next = cmd.target; // RULE_03
					discard = 1'b1; // RULE_21
				end
				seq_pkg::OP_CALL: begin
					pc_next = cmd.target;
					push    = 1'b1; // RULE_13
					discard = 1'b1;
				end
				seq_pkg::OP_RET, seq_pkg::OP_INTERRUPT_RETURN_OP: begin
					pc_next = stack_reg[0]; // RULE_10
					pop     = 1'b1;
					discard = 1'b1;
				end
				seq_pkg::OP_SKIP: discard = 1'b1; // RULE_04
				seq_pkg::OP_TABRD, seq_pkg::OP_TABLE_READ_LAST_PAGE_OP: begin
					pc_next   = pc_reg;
					tbl_start = 1'b1; // RULE_22
				end
				default: begin
					// Full stack withholds the acknowledge; the flag keeps waiting
					if (int_flag_reg && !full) begin // RULE_12
						int_take = 1'b1;
						push     = 1'b1;
						pc_next  = seq_pkg::INT_VECTOR;
						discard  = 1'b1;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Phase generator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_phases <= seq_pkg::PH_T1;
		end else begin
			case (cycle_phases) // RULE_20
				seq_pkg::PH_T1: cycle_phases <= seq_pkg::PH_T2;
				seq_pkg::PH_T2: cycle_phases <= seq_pkg::PH_T3;
				seq_pkg::PH_T3: cycle_phases <= seq_pkg::PH_T4;
				default:        cycle_phases <= seq_pkg::PH_T1;
			endcase
		end
	end

	// PC and fetch address; the address is presented from the first phase on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg    <= seq_pkg::RESET_VECTOR; // RULE_17
			pmem_addr <= seq_pkg::RESET_VECTOR;
		end else if (t4) begin
			pc_reg    <= pc_next;
			pmem_addr <= tbl_start ? tbl_addr : pc_next; // RULE_05
		end
	end

	// Instruction register; during a table cycle the prefetched word is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr           <= 16'h0000;
			instr_valid     <= 1'b0;
			table_cycle_reg <= 1'b0;
			tbl_dest_reg    <= 8'h00;
		end else if (t4) begin
			table_cycle_reg <= tbl_start;
			if (table_cycle_reg) begin
				instr_valid <= 1'b1;
			end else begin
				instr       <= pmem_rdata;
				instr_valid <= !discard && !tbl_start;
			end
			if (tbl_start) begin
				tbl_dest_reg <= cmd.dest;
			end
		end
	end

	// Return stack: entry 0 is newest, so a push when full shifts the oldest out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_reg[i] <= seq_pkg::RESET_VECTOR;
			end
			level_reg      <= '0; // RULE_11
			stack_overflow <= 1'b0;
		end else begin
			stack_overflow <= 1'b0;
			if (t4 && push) begin
				for (int i = STACK_DEPTH - 1; i > 0; i--) begin
					stack_reg[i] <= stack_reg[i-1]; // RULE_14
				end
				stack_reg[0] <= pc_reg; // RULE_09
				if (full) begin
					stack_overflow <= 1'b1;
				end else begin
					level_reg <= level_reg + LVL_ONE;
				end
			end else if (t4 && pop) begin
				for (int i = 0; i < STACK_DEPTH - 1; i++) begin
					stack_reg[i] <= stack_reg[i+1];
				end
				if (level_reg != '0) begin
					level_reg <= level_reg - LVL_ONE;
				end
			end
		end
	end

	// Interrupt flag: a new request wins over the acknowledge that clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_flag_reg <= 1'b0;
			int_ack      <= 1'b0;
		end else begin
			int_flag_reg <= int_req || (int_flag_reg && !(t4 && int_take)); // RULE_12
			int_ack      <= t4 && int_take;
		end
	end

	// Data memory write-back from the ALU or the table read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_wr             <= '0;
			status_flags        <= seq_pkg::FLAGS_RST;
			table_high_byte_reg <= 8'h00;
		end else begin
			data_wr.we <= 1'b0;
			if (t4 && table_cycle_reg) begin
				data_wr             <= '{we: 1'b1, dest: tbl_dest_reg, data: pmem_rdata[7:0]}; // RULE_19
				table_high_byte_reg <= pmem_rdata[15:8]; // RULE_23
			end else if (t4 && instr_valid && cmd.alu_en) begin
				data_wr      <= '{we: 1'b1, dest: cmd.dest, data: alu_out[7:0]}; // RULE_16
				status_flags <= alu_out[11:8]; // RULE_15
			end
		end
	end

	// ==========================================================
	// APB slave: pready rises one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok(paddr);
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready && !pwrite) begin
				// Stack contents and level have no address at all
				case (paddr) // RULE_08
					seq_pkg::OFS_PC_LOW:    prdata <= {24'h000000, pc_reg[7:0]}; // RULE_02
					seq_pkg::OFS_TBL_PTR_L: prdata <= {24'h000000, tblp_reg};
					seq_pkg::OFS_TBL_PTR_H: prdata <= {29'h00000000, tbhp_reg};
					seq_pkg::OFS_TBL_HIGH:  prdata <= {24'h000000, table_high_byte_reg};
					seq_pkg::OFS_STATUS:    prdata <= {27'h0000000, int_flag_reg, status_flags};
					default:                prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Register writes; the low byte write waits for the next cycle boundary that does not close a table cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tblp_reg     <= seq_pkg::TBL_PTR_RST;
			tbhp_reg     <= 3'h0;
			pcl_data_reg <= 8'h00;
			pcl_pend_reg <= 1'b0;
		end else begin
			if (t4 && !table_cycle_reg) begin
				pcl_pend_reg <= 1'b0;
			end
			if (apb_done && pwrite) begin
				case (paddr)
					seq_pkg::OFS_PC_LOW: begin
						pcl_data_reg <= pwdata[7:0];
						pcl_pend_reg <= 1'b1; // RULE_06
					end
					seq_pkg::OFS_TBL_PTR_L: tblp_reg <= pwdata[7:0]; // RULE_18
					seq_pkg::OFS_TBL_PTR_H: tbhp_reg <= pwdata[2:0];
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	AST_PHASE_WRAP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
		t4 |=> cycle_phases == seq_pkg::PH_T1 ##1 cycle_phases == seq_pkg::PH_T2)
		else $error("phase sequence broken");
	AST_PC_STEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
		t4 && !table_cycle_reg && !pcl_pend_reg && op_eff == seq_pkg::OP_NEXT && !int_take
		|=> pc_reg == $past(pc_reg) + seq_pkg::PC_STEP)
		else $error("pc did not advance by one");
	AST_JUMP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
		t4 && !table_cycle_reg && !pcl_pend_reg && op_eff == seq_pkg::OP_JUMP
		|=> (pc_reg == $past(cmd.target) && !instr_valid) ##1 !instr_valid [*3])
		else $error("jump target or dummy cycle wrong");
	AST_SKIP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
		t4 && !table_cycle_reg && !pcl_pend_reg && op_eff == seq_pkg::OP_SKIP |=> !instr_valid)
		else $error("skipped instruction not discarded");
	AST_PCL_PAGE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
		t4 && pcl_pend_reg && !table_cycle_reg |=> pc_reg == {$past(pc_reg[10:8]), $past(pcl_data_reg)}
		&& !instr_valid)
		else $error("low byte jump left page or missed dummy cycle");
	AST_PUSH: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
		t4 && push |=> stack_reg[0] == $past(pc_reg))
		else $error("push lost the pc");
	AST_POP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
		t4 && pop |=> pc_reg == $past(stack_reg[0]) && level_reg <= $past(level_reg))
		else $error("return did not restore the pc");
	AST_INT_HELD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
		t4 && int_flag_reg && full && !pop |=> !int_ack && int_flag_reg)
		else $error("interrupt taken with full stack");
	AST_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
		t4 && push && full |=> stack_overflow && level_reg == LVL_FULL
		&& stack_reg[STACK_DEPTH-1] == $past(stack_reg[STACK_DEPTH-2]))
		else $error("overflow kept wrong entries");
	AST_TBL_DATA: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
		t4 && table_cycle_reg |=> table_high_byte_reg == $past(pmem_rdata[15:8])
		&& data_wr.we && data_wr.data == $past(pmem_rdata[7:0]))
		else $error("table word split wrong");
	AST_TBL_TWO: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
		t4 && tbl_start |=> table_cycle_reg [*4] ##1 !table_cycle_reg)
		else $error("table read not two cycles");
endmodule : program_sequencer

`default_nettype wire

// ### core/seq_pkg.sv
// Shared constants, enumerations and carrier types of the program sequencer
package seq_pkg;
	// ==========================================================
	// Address and memory geometry
	localparam int          PC_W          = 11;
	localparam logic [10:0] RESET_VECTOR  = 11'h000;
	localparam logic [10:0] INT_VECTOR    = 11'h004;
	localparam logic [2:0]  LAST_PAGE     = 3'h7;
	localparam logic [10:0] PC_STEP       = 11'h001;

	// ==========================================================
	// Register offsets on the APB side
	localparam logic [7:0]  OFS_PC_LOW    = 8'h00;
	localparam logic [7:0]  OFS_TBL_PTR_L = 8'h04;
	localparam logic [7:0]  OFS_TBL_PTR_H = 8'h08;
	localparam logic [7:0]  OFS_TBL_HIGH  = 8'h0c;
	localparam logic [7:0]  OFS_STATUS    = 8'h10;

	// ==========================================================
	// Reset values and flag positions
	localparam logic [7:0]  TBL_PTR_RST   = 8'h00;
	localparam logic [3:0]  FLAGS_RST     = 4'h0;
	localparam int          FLAG_C        = 0;
	localparam int          FLAG_AC       = 1;
	localparam int          FLAG_Z        = 2;
	localparam int          FLAG_OV       = 3;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		PH_T1 = 2'b00,
		PH_T2 = 2'b01,
		PH_T3 = 2'b11,
		PH_T4 = 2'b10
	} phase_t;

	typedef enum logic [3:0] {
		OP_NEXT   = 4'h0,
		OP_JUMP   = 4'h1,
		OP_CALL   = 4'h2,
		OP_RET    = 4'h3,
		OP_INTERRUPT_RETURN_OP   = 4'h4,
		OP_SKIP   = 4'h5,
		OP_TABRD  = 4'h6,
		OP_TABLE_READ_LAST_PAGE_OP = 4'h7
	} seq_op_t;

	typedef enum logic [3:0] {
		ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
		ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR  = 4'h6, ALU_XOR = 4'h7,
		ALU_CPL = 4'h8, ALU_RR  = 4'h9, ALU_RRC = 4'ha, ALU_RL  = 4'hb,
		ALU_RLC = 4'hc, ALU_INC = 4'hd, ALU_DEC = 4'he
	} alu_op_t;

	typedef struct packed {
		seq_op_t     op;
		logic        alu_en;
		alu_op_t     alu;
		logic [10:0] target;
		logic [7:0]  dest;
		logic [7:0]  opa;
		logic [7:0]  opm;
	} seq_cmd_t;

	typedef struct packed {
		logic       we;
		logic [7:0] dest;
		logic [7:0] data;
	} data_wr_t;
endpackage : seq_pkg

// ### test/pmem_model.sv
// Program memory model: fixed word pattern answering fetch and table addresses
`timescale 1ns/100ps
`default_nettype none

module pmem_model (
	input  wire logic [10:0] addr,
	output var  logic [15:0] rdata
);
	// ==========================================================
	// Read port
	// Combinational, so the word is ready in the same cycle the address moves
	always_comb begin
		rdata = {addr[4:0], addr} ^ 16'h5a3c;
	end
endmodule : pmem_model

`default_nettype wire

// ### test/tb_program_sequencer.sv
// Self-checking bench of the program sequencer against a queue-based reference
`timescale 1ns/100ps
`default_nettype none

module tb_program_sequencer;
	localparam int D = 4;
	logic	pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic	int_req, instr_valid, int_ack, stack_overflow;
	logic [7:0]	paddr;
	logic [31:0]	pwdata, prdata;
	logic [15:0]	pmem_rdata, instr;
	logic [10:0]	pmem_addr;
	logic [3:0]	status_flags;
	seq_pkg::seq_cmd_t	cmd;
	seq_pkg::phase_t	cycle_phases;
	seq_pkg::data_wr_t	data_wr;
	int	fails, cmp_count;
	// ==========================================================
	// Reference state: next fetch, validity, stack, pending work
	logic [10:0]	ea, ta, stk[$];
	logic	ev, ip, ep, sync, tb_on, ack_e, ovf_e, we_e, ec;
	logic [7:0]	pcl_new, wd_e, dst_e;

	program_sequencer #(.STACK_DEPTH(D)) program_sequencer_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd(cmd), .int_req(int_req), .pmem_rdata(pmem_rdata),
		.pmem_addr(pmem_addr), .instr(instr), .instr_valid(instr_valid), .cycle_phases(cycle_phases),
		.data_wr(data_wr), .status_flags(status_flags), .int_ack(int_ack), .stack_overflow(stack_overflow));
	pmem_model pmem_model_inst (.addr(pmem_addr), .rdata(pmem_rdata));

	// ==========================================================
	// Clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ==========================================================
	// Helpers
	task automatic results;
		$display("Checks %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	function automatic logic [15:0] word(input logic [10:0] a);
		return {a[4:0], a} ^ 16'h5a3c;
	endfunction : word

	function automatic seq_pkg::seq_cmd_t mk(input seq_pkg::seq_op_t o, input logic [10:0] t);
		mk = '0;
		mk.op = o;
		mk.target = t;
	endfunction : mk

	// Carry in bit 8; ops that leave the carry alone return the old one
	function automatic logic [8:0] alu_f(input seq_pkg::alu_op_t o, input logic [7:0] a, input logic [7:0] m);
		logic [8:0] d;
		d = {1'b0, a} + 9'h006;
		case (o)
			// Low nibble is kept above nine by the stimulus, so the half carry plays no part
			seq_pkg::ALU_DAA: return (d[7:4] > 4'h9 || ec || d[8]) ? {1'b1, 8'(d + 9'h060)} : {ec, d[7:0]};
			seq_pkg::ALU_ADD: return a + m;
			seq_pkg::ALU_ADC: return a + m + ec;
			seq_pkg::ALU_SUB: return a + {1'b0, ~m} + 9'h001;
			seq_pkg::ALU_SBC: return a + {1'b0, ~m} + ec;
			seq_pkg::ALU_AND: return {ec, a & m};
			seq_pkg::ALU_OR:  return {ec, a | m};
			seq_pkg::ALU_XOR: return {ec, a ^ m};
			seq_pkg::ALU_CPL: return {ec, ~m};
			seq_pkg::ALU_RR:  return {ec, m[0], m[7:1]};
			seq_pkg::ALU_RRC: return {m[0], ec, m[7:1]};
			seq_pkg::ALU_RL:  return {ec, m[6:0], m[7]};
			seq_pkg::ALU_RLC: return {m[7], m[6:0], ec};
			seq_pkg::ALU_INC: return {ec, m + 8'h01};
			seq_pkg::ALU_DEC: return {ec, m - 8'h01};
			default: return {ec, 8'h00};
		endcase
	endfunction : alu_f

	// Reference update for one instruction boundary
	task automatic mstep(input seq_pkg::seq_cmd_t c);
		logic [10:0] pa;
		logic [8:0] r;
		logic [15:0] w;
		pa = ea;
		{ack_e, ovf_e, we_e} = 3'h0;
		if (ev && c.alu_en) begin
			r = alu_f(c.alu, c.opa, c.opm);
			{we_e, wd_e, dst_e, ec} = {1'b1, r[7:0], c.dest, r[8]};
		end
		if (tb_on) begin
			w = word(ta);
			{tb_on, we_e, wd_e, ev} = {1'b0, 1'b1, w[7:0], 1'b1};
		end else if (ep) begin
			{ea, ev, ep} = {pa[10:8], pcl_new, 2'b00};
		end else if (!ev || c.op == seq_pkg::OP_NEXT) begin
			if (ip && stk.size() < D) begin
				stk.push_back(pa);
				{ea, ev, ip, ack_e} = {seq_pkg::INT_VECTOR, 3'b001};
			end else
				{ea, ev} = {pa + 11'h001, 1'b1};
		end else case (c.op)
			seq_pkg::OP_JUMP: {ea, ev, sync} = {c.target, 2'b01};
			seq_pkg::OP_CALL: begin
				ovf_e = (stk.size() == D);
				if (ovf_e) void'(stk.pop_front());
				stk.push_back(pa);
				{ea, ev} = {c.target, 1'b0};
			end
			seq_pkg::OP_RET, seq_pkg::OP_INTERRUPT_RETURN_OP: {ea, ev} = {stk.pop_back(), 1'b0};
			seq_pkg::OP_SKIP: {ea, ev} = {pa + 11'h001, 1'b0};
			default: {ta, ea, ev, sync, tb_on, dst_e} = {c.target, c.target, 3'b001, c.dest};
		endcase
	endtask : mstep

	// One instruction slot: command held until the boundary, outputs checked after it
	task automatic cyc(input seq_pkg::seq_cmd_t c, input logic irq);
		int n;
		logic [10:0] pa;
		logic al;
		cmd <= c;
		int_req <= irq;
		n = 0;
		do @(negedge pclk);
		while (cycle_phases !== seq_pkg::PH_T4 && ++n < 9);
		if (n >= 9) begin
			fails++;
			results();
		end
		@(posedge pclk);
		cmd <= mk(seq_pkg::OP_NEXT, 11'h000);
		int_req <= 1'b0;
		ip |= irq;
		pa = ea;
		al = ev && c.alu_en;
		mstep(c);
		@(negedge pclk);
		if (sync) begin
			chk("pmem_addr", pmem_addr, ea);
			chk("instr_valid", instr_valid, ev);
			if (ev) chk("instr", instr, word(pa));
		end
		chk("int_ack", int_ack, ack_e);
		chk("overflow", stack_overflow, ovf_e);
		chk("wr_en", data_wr.we, we_e);
		if (we_e) begin
			chk("wr_data", data_wr.data, wd_e);
			chk("wr_dest", data_wr.dest, dst_e);
		end
		if (al) begin
			chk("carry", status_flags[seq_pkg::FLAG_C], ec);
			chk("zero", status_flags[seq_pkg::FLAG_Z], wd_e == 8'h00);
		end
		@(posedge pclk);
	endtask : cyc

	task automatic op(input seq_pkg::seq_op_t o, input logic irq);
		cyc(mk(o, 11'($urandom())), irq);
	endtask : op

	// APB transfer started at a rising edge, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ed,
		input logic ee);
		int n;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk);
		while (pready !== 1'b1 && ++n < 9);
		if (n >= 9) begin
			fails++;
			results();
		end
		if (!w) chk("prdata", prdata, ed);
		chk("pslverr", pslverr, ee);
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask : apb

	// Slot count is lost while the bus runs; only the next jump resyncs, a table read leaves it lost
	task automatic lost;
		{sync, ev} = 2'b01;
	endtask : lost

	// ==========================================================
	// Main sequence
	initial begin
		int i;
		logic [7:0] v;
		seq_pkg::seq_cmd_t c;
		{presetn, psel, penable, pwrite, paddr, pwdata, int_req} = '0;
		cmd = '0;
		{fails, cmp_count} = '0;
		{ea, ev, ip, ep, sync, tb_on, ec} = {11'h000, 6'b000100};
		void'($urandom(32'hcc72));
		repeat (3) @(posedge pclk);
		chk("reset_addr", pmem_addr, seq_pkg::RESET_VECTOR);
		presetn <= 1'b1;
		repeat (3) op(seq_pkg::OP_NEXT, 1'b0);
		$display("Done: sequential fetch");
		// Jumps in the dummy slots must be ignored; the skip lands in a live slot
		for (i = 0; i < 4; i++) op(i == 2 ? seq_pkg::OP_SKIP : seq_pkg::OP_JUMP, 1'b0);
		repeat (2) op(seq_pkg::OP_NEXT, 1'b0);
		$display("Done: jump and skip");
		// Low byte readback, then a write lands at the boundary after the transfer
		op(seq_pkg::OP_NEXT, 1'b0);
		apb(1'b0, seq_pkg::OFS_PC_LOW, 32'h0, {24'h0, ea[7:0]}, 1'b0);
		mstep(mk(seq_pkg::OP_NEXT, 11'h000));
		op(seq_pkg::OP_NEXT, 1'b0);
		@(posedge pclk);
		v = 8'($urandom());
		apb(1'b1, seq_pkg::OFS_PC_LOW, {24'h0, v}, 32'h0, 1'b0);
		mstep(mk(seq_pkg::OP_NEXT, 11'h000));
		{ep, pcl_new} = {1'b1, v};
		repeat (3) op(seq_pkg::OP_NEXT, 1'b0);
		$display("Done: low byte write");
		// Fill the stack, defer an interrupt, overflow, then unwind
		for (i = 0; i < D; i++) begin
			op(seq_pkg::OP_CALL, 1'b0);
			op(seq_pkg::OP_NEXT, 1'b0);
		end
		op(seq_pkg::OP_NEXT, 1'b1);
		op(seq_pkg::OP_CALL, 1'b0);
		op(seq_pkg::OP_NEXT, 1'b0);
		for (i = 0; i < D + 1; i++) begin
			op(i == 1 ? seq_pkg::OP_INTERRUPT_RETURN_OP : seq_pkg::OP_RET, 1'b0);
			repeat (i == 0 ? 2 : 1) op(seq_pkg::OP_NEXT, 1'b0);
		end
		$display("Done: stack and interrupt");
		for (i = 0; i < 15; i++) begin
			c = mk(seq_pkg::OP_NEXT, 11'h000);
			c.alu_en = 1'b1;
			c.alu = seq_pkg::alu_op_t'((i + 5) % 15);
			{c.dest, c.opa, c.opm} = 24'($urandom());
			if (c.alu == seq_pkg::ALU_DAA) c.opa[3:0] = c.opa[3:0] | 4'ha;
			cyc(c, 1'b0);
		end
		$display("Done: alu");
		// Table reads through both pointer forms
		for (i = 0; i < 2; i++) begin
			v = 8'($urandom());
			apb(1'b1, seq_pkg::OFS_TBL_PTR_L, {24'h0, v}, 32'h0, 1'b0);
			apb(1'b1, seq_pkg::OFS_TBL_PTR_H, 32'h5, 32'h0, 1'b0);
			lost();
			c = mk(i ? seq_pkg::OP_TABLE_READ_LAST_PAGE_OP : seq_pkg::OP_TABRD, {i ? seq_pkg::LAST_PAGE : 3'h5, v});
			c.dest = 8'($urandom());
			cyc(c, 1'b0);
			chk("table_addr", pmem_addr, c.target);
			op(seq_pkg::OP_NEXT, 1'b0);
			apb(1'b0, seq_pkg::OFS_TBL_HIGH, 32'h0, 32'(word(ta) >> 8), 1'b0);
			apb(1'b1, seq_pkg::OFS_TBL_HIGH, 32'hff, 32'h0, 1'b0);
			apb(1'b0, seq_pkg::OFS_TBL_HIGH, 32'h0, 32'(word(ta) >> 8), 1'b0);
			lost();
			op(seq_pkg::OP_JUMP, 1'b0);
		end
		apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
		$display("Done: table and register map");
		results();
	end
endmodule : tb_program_sequencer

`default_nettype wire
